//--- shared/vasr_params.svh
// Purpose: Offsets, field positions, reset values and counts of the ancillary/status bank
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Definitions only
`ifndef VASR_PARAMS_SVH
`define VASR_PARAMS_SVH
// ----------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------
`define VASR_ADDR_W        16
`define VASR_IDX_IDENT     12'h40a
`define VASR_IDX_AUDIO     12'h40b
`define VASR_IDX_CP        12'h40c
`define VASR_IDX_GS1       12'h40d
`define VASR_IDX_GS2       12'h40e
`define VASR_IDX_OUTCTL    12'h41f
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VASR_ID1_LSB       2
`define VASR_ID0_LSB       0
`define VASR_AUDIO_GROUP_SEL_LSB   6
`define VASR_AUD_RATE_LSB  4
`define VASR_AUD_GLOBAL    3
`define VASR_TEN_BIT_POS   2
`define VASR_VQUAL_POS     0
`define VASR_OUTCTL_MASK   8'h05
`define VASR_IDENT_MASK    8'h0f
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VASR_RST_BYTE      8'h00
`define VASR_RST_STANDARD  4'h1
// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define VASR_VSYNC_WINDOW  10'h002
`define VASR_HSYNC_HIST    32
`define VASR_VSYNC_HIST    16
`define VASR_HSYNC_TOL     8'h04
`define VASR_RESP_OKAY     2'h0
`define VASR_RESP_DECERR   2'h3
`endif

//--- shared/vasr_pkg.sv
// Purpose: Types of the ancillary/status bank
// Assumes: Widths fixed by the bank layout
// Notes:   Constants live in vasr_params.svh
package vasr_pkg;
   // Register selected by a decoded address
   typedef enum logic [2:0] {SEL_NONE, SEL_IDENT, SEL_AUDIO, SEL_CP, SEL_GS1, SEL_GS2, SEL_OUTCTL} vasr_sel_t;

   // Whole state of the bank module
   typedef struct packed {
      logic        awReady;
      logic        wReady;
      logic        awHave;
      logic        wHave;
      logic [15:0] awAddr;
      logic [7:0]  wData;
      logic        wLane0;
      logic        bValid;
      logic [1:0]  bResp;
      logic        arReady;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
      logic [3:0]  identLow;
      logic [7:0]  audioCtrl;
      logic [7:0]  outCtrl;
      logic [7:0]  cpStat;
      logic [7:0]  gs1;
      logic [7:0]  gs2;
      logic        specialPlayN;
      logic        videoPresent;
      logic [1:0]  firstIdLow;
      logic [1:0]  secondIdLow;
      logic [1:0]  groupSel;
      logic [1:0]  rateSel;
      logic [2:0]  insertEn;
      logic        tenBit;
   } vasr_state_t;
endpackage : vasr_pkg

//--- shared/vasr_hist_if.sv
// Purpose: Carries sync pulses and their verdict between bank and history tracker
// Assumes: All signals on the device clock
// Notes:   One instance per sync kind
`timescale 1ns/1ps
interface vasr_hist_if;
   logic pulse;
   logic hit;
   logic allNear;
   modport tracker (input pulse, input hit, output allNear);
   modport feeder  (output pulse, output hit, input allNear);
endinterface : vasr_hist_if

//--- logic/vasr_hit_history.sv
// Purpose: Remembers whether the last DEPTH sync pulses were near their expected place
// Assumes: pulse is one cycle wide, hit valid with it
// Notes:   allNear stays low until DEPTH pulses have been seen
`timescale 1ns/1ps
module vasr_hit_history
   import vasr_pkg::*;
#(
   parameter int DEPTH = 32
)(
   input  wire logic clock,
   input  wire logic rst,
   vasr_hist_if.tracker hist
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0] bits;
      logic [CW-1:0]    seen;
      logic             allNear;
   } vasr_hist_state_t;

   vasr_hist_state_t s_r;
   vasr_hist_state_t s_nxt;

   // Shift in each pulse verdict, count pulses up to DEPTH
   always_comb
   begin
      s_nxt = s_r;
      if (hist.pulse)
      begin
         s_nxt.bits = {s_r.bits[DEPTH-2:0], hist.hit};
         if (s_r.seen != CW'(DEPTH))
            s_nxt.seen = s_r.seen + CW'(1);
      end
      s_nxt.allNear = (s_nxt.seen == CW'(DEPTH)) && (&s_nxt.bits);
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign hist.allNear = s_r.allNear;
endmodule : vasr_hit_history

//--- logic/vasr_status_bank.sv
// Purpose: Ancillary ident/audio control and read-only video status bank on AXI4-Lite
// Assumes: Detector inputs come from logic on the same clock; 32-bit data, byte-wide registers
// Notes:   Status is snapshotted every cycle so a read returns one coherent byte
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "vasr_params.svh"
module vasr_status_bank
   import vasr_pkg::*;
#(
   parameter logic [7:0] HSYNC_TOL = `VASR_HSYNC_TOL
)(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpPulsePairDetected,
   input  wire logic        cpThirdKindStripe,
   input  wire logic        cpColourStripe,
   input  wire logic        cpPseudoSync,
   input  wire logic        vsyncLevel,
   input  wire logic        rateConvFifoUnderflow,
   input  wire logic        rateConvFifoOverflow,
   input  wire logic        fieldOdd,
   input  wire logic [3:0]  detectedStandardCode,
   input  wire logic        gainCtrlLocked,
   input  wire logic        subcarrierLocked,
   input  wire logic        verticalLocked,
   input  wire logic        rateConvLocked,
   input  wire logic        horizontalLocked,
   input  wire logic        vsyncPulse,
   input  wire logic [9:0]  currentLine,
   input  wire logic [9:0]  expectedVsyncLine,
   input  wire logic        hsyncPulse,
   input  wire logic [7:0]  hsyncPhaseError,
   output logic [1:0]       firstAncIdentWordLow,
   output logic [1:0]       secondAncIdentWordLow,
   output logic             tenBitOutputSel,
   output logic [1:0]       audioGroupSel,
   output logic [1:0]       audioSampleRate,
   output logic [2:0]       fifoInsertEnable,
   output logic             specialPlayN,
   output logic             videoPresentFlag
);
   // ----------------------------------------------------------------
   // Sync history trackers
   // ----------------------------------------------------------------
   vasr_hist_if hHist ();
   vasr_hist_if vHist ();

   logic [9:0] lineDist;
   logic       vsyncNear;

   // Distance of detected vsync from its expected line
   assign lineDist  = (currentLine >= expectedVsyncLine) ? (currentLine - expectedVsyncLine)
                                                         : (expectedVsyncLine - currentLine);
   assign vsyncNear = (lineDist <= `VASR_VSYNC_WINDOW);

   // Feed pulses and their verdicts to the trackers
   assign hHist.pulse = hsyncPulse;
   assign hHist.hit   = (hsyncPhaseError <= HSYNC_TOL);
   assign vHist.pulse = vsyncPulse;
   assign vHist.hit   = vsyncNear;

   vasr_hit_history #(.DEPTH(`VASR_HSYNC_HIST)) hTrack
   (
      .clock (clock),
      .rst   (rst),
      .hist  (hHist.tracker)
   );

   vasr_hit_history #(.DEPTH(`VASR_VSYNC_HIST)) vTrack
   (
      .clock (clock),
      .rst   (rst),
      .hist  (vHist.tracker)
   );

   // ----------------------------------------------------------------
   // Address decode and read mux
   // ----------------------------------------------------------------
   function automatic vasr_sel_t decode(input logic [15:0] addr);
      vasr_sel_t sel;
      sel = SEL_NONE;
      if (addr[15:14] == 2'h0)
      begin
         case (addr[13:2])
            `VASR_IDX_IDENT  : sel = SEL_IDENT;
            `VASR_IDX_AUDIO  : sel = SEL_AUDIO;
            `VASR_IDX_CP     : sel = SEL_CP;
            `VASR_IDX_GS1    : sel = SEL_GS1;
            `VASR_IDX_GS2    : sel = SEL_GS2;
            `VASR_IDX_OUTCTL : sel = SEL_OUTCTL;
            default          : sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction : decode

   function automatic logic [7:0] readByte(input vasr_sel_t sel, input vasr_state_t st);
      logic [7:0] b;
      b = 8'h00;
      case (sel)
         SEL_IDENT  : b = {4'h0, st.identLow};
         SEL_AUDIO  : b = st.audioCtrl;
         SEL_CP     : b = st.cpStat;
         SEL_GS1    : b = st.gs1;
         SEL_GS2    : b = st.gs2;
         SEL_OUTCTL : b = st.outCtrl;
         default    : b = 8'h00;
      endcase
      return b;
   endfunction : readByte

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   vasr_state_t s_r;
   vasr_state_t s_nxt;
   vasr_sel_t   wSel;
   logic        cpStripe;
   logic [1:0]  cpCode;

   assign wSel     = decode(s_r.awAddr);
   assign cpStripe = cpColourStripe | cpThirdKindStripe;
   // Copy-control code: none, pseudo sync, plus stripe, plus third-kind stripe
   assign cpCode   = !cpPseudoSync      ? 2'h0 :
                     cpThirdKindStripe  ? 2'h3 :
                     cpStripe           ? 2'h2 : 2'h1;

   // Next-state logic: bus handshakes, register writes, status snapshot
   always_comb
   begin
      s_nxt = s_r;
      // Write address and data are taken independently
      if (s_axi_awvalid && s_r.awReady)
      begin
         s_nxt.awHave  = 1'b1;
         s_nxt.awAddr  = s_axi_awaddr;
         s_nxt.awReady = 1'b0;
      end
      if (s_axi_wvalid && s_r.wReady)
      begin
         s_nxt.wHave  = 1'b1;
         s_nxt.wData  = s_axi_wdata[7:0];
         s_nxt.wLane0 = s_axi_wstrb[0];
         s_nxt.wReady = 1'b0;
      end
      // Perform the write once both halves are held
      if (s_r.awHave && s_r.wHave && !s_r.bValid)
      begin
         s_nxt.bValid = 1'b1;
         s_nxt.bResp  = (wSel == SEL_NONE) ? `VASR_RESP_DECERR : `VASR_RESP_OKAY;
         if (s_r.wLane0)
         begin
            case (wSel)
               SEL_IDENT  : s_nxt.identLow  = s_r.wData[3:0];
               SEL_AUDIO  : s_nxt.audioCtrl = s_r.wData;
               SEL_OUTCTL : s_nxt.outCtrl   = s_r.wData & `VASR_OUTCTL_MASK;
               default    : s_nxt.bResp     = s_nxt.bResp;
            endcase
         end
      end
      // Response retires, channels reopen
      if (s_r.bValid && s_axi_bready)
      begin
         s_nxt.bValid  = 1'b0;
         s_nxt.awHave  = 1'b0;
         s_nxt.wHave   = 1'b0;
         s_nxt.awReady = 1'b1;
         s_nxt.wReady  = 1'b1;
      end
      // Read: answer one cycle after the address is taken
      if (s_axi_arvalid && s_r.arReady)
      begin
         s_nxt.arReady = 1'b0;
         s_nxt.rValid  = 1'b1;
         s_nxt.rData   = {24'h000000, readByte(decode(s_axi_araddr), s_r)};
         s_nxt.rResp   = (decode(s_axi_araddr) == SEL_NONE) ? `VASR_RESP_DECERR : `VASR_RESP_OKAY;
      end
      if (s_r.rValid && s_axi_rready)
      begin
         s_nxt.rValid  = 1'b0;
         s_nxt.arReady = 1'b1;
      end
      // Status snapshot, one byte per register
      s_nxt.cpStat = {cpPulsePairDetected, cpThirdKindStripe, cpStripe, cpPseudoSync,
                      2'h0, cpCode};
      s_nxt.gs1    = {vsyncLevel, rateConvFifoUnderflow, rateConvFifoOverflow, fieldOdd,
                      detectedStandardCode};
      // Special play updates on each detected vsync
      if (vsyncPulse)
         s_nxt.specialPlayN = vsyncNear;
      // Presence: hsync history, optionally qualified by vsync history
      s_nxt.videoPresent = hHist.allNear &&
                           (!s_r.outCtrl[`VASR_VQUAL_POS] || vHist.allNear);
      s_nxt.gs2    = {1'b0, s_r.specialPlayN, s_r.videoPresent, gainCtrlLocked, subcarrierLocked,
                      verticalLocked, rateConvLocked, horizontalLocked};
      // Outputs driven from the control registers
      s_nxt.tenBit      = s_nxt.outCtrl[`VASR_TEN_BIT_POS];
      s_nxt.firstIdLow  = s_nxt.tenBit ? s_nxt.identLow[`VASR_ID0_LSB +: 2] : 2'h0;
      s_nxt.secondIdLow = s_nxt.tenBit ? s_nxt.identLow[`VASR_ID1_LSB +: 2] : 2'h0;
      s_nxt.groupSel    = s_nxt.audioCtrl[`VASR_AUDIO_GROUP_SEL_LSB +: 2];
      s_nxt.rateSel     = s_nxt.audioCtrl[`VASR_AUD_RATE_LSB +: 2];
      s_nxt.insertEn    = {3{s_nxt.audioCtrl[`VASR_AUD_GLOBAL]}} & s_nxt.audioCtrl[2:0];
   end

   // State register with reset values
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_r           <= '0;
         s_r.awReady   <= 1'b1;
         s_r.wReady    <= 1'b1;
         s_r.arReady   <= 1'b1;
         s_r.audioCtrl <= `VASR_RST_BYTE;
         s_r.gs1       <= {4'h0, `VASR_RST_STANDARD};
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready         = s_r.awReady;
   assign s_axi_wready          = s_r.wReady;
   assign s_axi_bvalid          = s_r.bValid;
   assign s_axi_bresp           = s_r.bResp;
   assign s_axi_arready         = s_r.arReady;
   assign s_axi_rvalid          = s_r.rValid;
   assign s_axi_rdata           = s_r.rData;
   assign s_axi_rresp           = s_r.rResp;
   assign firstAncIdentWordLow  = s_r.firstIdLow;
   assign secondAncIdentWordLow = s_r.secondIdLow;
   assign tenBitOutputSel       = s_r.tenBit;
   assign audioGroupSel         = s_r.groupSel;
   assign audioSampleRate       = s_r.rateSel;
   assign fifoInsertEnable      = s_r.insertEn;
   assign specialPlayN          = s_r.specialPlayN;
   assign videoPresentFlag      = s_r.videoPresent;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Control outputs follow the register bytes
   a_second_ident_gate: assert property (secondAncIdentWordLow == (tenBitOutputSel ? s_r.identLow[3:2] : 2'h0))
      else $error("second ident bits not gated by ten-bit select");
   a_first_ident_gate: assert property (!tenBitOutputSel |-> firstAncIdentWordLow == 2'h0)
      else $error("first ident bits leak in eight-bit mode");
   a_first_ident_pass: assert property (tenBitOutputSel |-> firstAncIdentWordLow == s_r.identLow[1:0])
      else $error("first ident bits not passed in ten-bit mode");
   a_group_follows: assert property (s_r.bValid && !$past(s_r.bValid) && $past(wSel) == SEL_AUDIO
                                     && $past(s_r.wLane0) |=> audioGroupSel == $past(s_r.wData[7:6], 2))
      else $error("audio group output does not follow write");
   a_rate_field: assert property (audioSampleRate == s_r.audioCtrl[5:4])
      else $error("sample rate output mismatch");
   a_insert_global: assert property (fifoInsertEnable != 3'h0 |-> s_r.audioCtrl[3])
      else $error("insertion enabled without global enable");
   a_fifo_map: assert property (s_r.audioCtrl[3] |-> fifoInsertEnable == s_r.audioCtrl[2:0])
      else $error("per-FIFO enable mapping wrong");

   // Status bytes carry the detector levels one cycle later
   a_cp_layout: assert property (##1 s_r.cpStat[7] == $past(cpPulsePairDetected)
                                 && s_r.cpStat[4] == $past(cpPseudoSync))
      else $error("copy-protection bits misplaced");
   a_third_forces: assert property (s_r.cpStat[6] |-> s_r.cpStat[5])
      else $error("third-kind stripe without colour stripe");
   a_code_zero: assert property ((s_r.cpStat[1:0] == 2'h0) == !s_r.cpStat[4])
      else $error("copy-control code inconsistent");
   a_stripe_forced: assert property (cpThirdKindStripe && !rst |=> s_r.cpStat[6] && s_r.cpStat[5])
      else $error("third-kind stripe did not set both stripe bits");
   a_status_one: assert property (!rst |=> s_r.gs1 == $past({vsyncLevel, rateConvFifoUnderflow,
                                  rateConvFifoOverflow, fieldOdd, detectedStandardCode}))
      else $error("general status one byte misplaced");
   a_std_reset: assert property (@(posedge clock) $fell(rst) |-> s_r.gs1[3:0] == 4'h1)
      else $error("standard code not reset to one");
   a_special_window: assert property (vsyncPulse && lineDist > 10'h002 |=> !specialPlayN)
      else $error("special play not flagged outside window");
   a_special_inside: assert property (vsyncPulse && lineDist <= 10'h002 |=> specialPlayN)
      else $error("special play flagged inside window");
   a_present_h_only: assert property (!s_r.outCtrl[0] && !hHist.allNear |=> !videoPresentFlag)
      else $error("presence without hsync history");
   a_present_v_qual: assert property (s_r.outCtrl[0] && hHist.allNear && !vHist.allNear |=> !videoPresentFlag)
      else $error("qualified presence ignores vsync history");
   a_lock_snapshot: assert property (##1 s_r.gs2[0] == $past(horizontalLocked))
      else $error("horizontal lock flag misplaced");
   a_flags_lag: assert property (!rst |=> s_r.gs2[6:5] == $past({specialPlayN, videoPresentFlag}))
      else $error("special play or presence bit misplaced in status two");

   // Bus answers, reserved bits and snapshots
   a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && s_r.gs2[7] == 1'b0)
      else $error("reserved bits read nonzero");
   a_read_snapshot: assert property (s_axi_arvalid && s_axi_arready && decode(s_axi_araddr) == SEL_GS1
                                     |=> s_axi_rdata[7:0] == $past(s_r.gs1))
      else $error("read is not a snapshot of the register");
   a_write_answer: assert property (s_r.awHave && s_r.wHave && !s_r.bValid |=> s_axi_bvalid)
      else $error("write response late");
   a_decerr_write: assert property (s_axi_bvalid && wSel == SEL_NONE |-> s_axi_bresp == `VASR_RESP_DECERR)
      else $error("unmapped write not answered with decode error");
   a_outctl_reserved: assert property ((s_r.outCtrl & ~`VASR_OUTCTL_MASK) == 8'h00)
      else $error("reserved output control bits set");

   // Main scenarios that the bench must reach
   c_write_audio: cover property (s_axi_bvalid && s_axi_bready && wSel == SEL_AUDIO);
   c_read_status: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[5]);
   c_special_play: cover property (vsyncPulse && !vsyncNear);
   c_insert_all: cover property (fifoInsertEnable == 3'h7);
   c_present_qualified: cover property (videoPresentFlag && s_r.outCtrl[`VASR_VQUAL_POS]);
endmodule : vasr_status_bank

//--- verification/vasr_status_bank_tb_top.sv
// Purpose: Self-checking bench of the ancillary ident, audio control and status bank
// Assumes: AXI4-Lite byte address is register index times four
// Notes:   Table rows first, then status snapshot, special play and presence cases
`timescale 1ns/1ps
module vasr_status_bank_tb_top
   import vasr_pkg::*;
();
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   typedef struct packed {logic [15:0] a; logic [7:0] wd; logic [7:0] rd; logic [1:0] resp; logic [11:0] outs;} vasr_row_t;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] awAddr = 16'h0000, arAddr = 16'h0000;
   logic [31:0] wData = 32'h00000000;
   logic [3:0]  wStrb = 4'h0;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid, tenBit, spN, video_present_flag;
   logic [1:0]  bResp, rResp, firstLow, secondLow, grpSel, rateSel, resp;
   logic [31:0] rData, rd;
   logic [2:0]  fifoEn;
   logic [16:0] det = {4'h0, 8'h01, 5'h00};  // Copy-protection nibble, status one byte, lock flags
   logic        vsPulse = 1'b0, hsPulse = 1'b0;
   logic [9:0]  curLine = 10'h000;
   logic [9:0]  expLine = 10'h064;
   logic [7:0]  hsErr = 8'h00, cpE;
   int          n_mismatch = 0, n_checks = 0;
   // Write, read back, outputs {first, second, ten-bit, group, rate, fifo enables}
   vasr_row_t   rows [10] = '{'{16'h107c, 8'hff, 8'h05, 2'h0, 12'h080}, '{16'h1028, 8'hfe, 8'h0e, 2'h0, 12'hb80},
      '{16'h102c, 8'hc8, 8'hc8, 2'h0, 12'hbe0}, '{16'h102c, 8'h5f, 8'h5f, 2'h0, 12'hbaf},
      '{16'h102c, 8'ha7, 8'ha7, 2'h0, 12'hbd0}, '{16'h102c, 8'h3d, 8'h3d, 2'h0, 12'hb9d},
      '{16'h107c, 8'h00, 8'h00, 2'h0, 12'h01d}, '{16'h1030, 8'hff, 8'h00, 2'h0, 12'h01d},
      '{16'h1038, 8'hff, 8'h00, 2'h0, 12'h01d}, '{16'h4028, 8'hff, 8'h00, 2'h3, 12'h01d}};
   logic [16:0] pats [5] = '{{4'h4, 8'h8c, 5'h15}, {4'h5, 8'h61, 5'h0a}, {4'h3, 8'h18, 5'h1f},
      {4'h9, 8'h48, 5'h01}, {4'h0, 8'h01, 5'h00}};
   logic [3:0]  codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc};
   logic [10:0] spRows [5] = '{{10'd102, 1'b1}, {10'd103, 1'b0}, {10'd98, 1'b1}, {10'd97, 1'b0}, {10'd100, 1'b1}};
   // Presence rows: {phase error, hsync count, qualify, vsync count, expected flag}
   logic [20:0] prRows [6] = '{{8'h04, 6'd31, 1'b0, 5'd0, 1'b0}, {8'h04, 6'd1, 1'b0, 5'd0, 1'b1},
      {8'h05, 6'd1, 1'b0, 5'd0, 1'b0}, {8'h04, 6'd32, 1'b0, 5'd0, 1'b1}, {8'h04, 6'd1, 1'b1, 5'd0, 1'b0},
      {8'h04, 6'd1, 1'b1, 5'd16, 1'b1}};

   vasr_status_bank i_vasr_status_bank (.clock(clock), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .cpPulsePairDetected(det[16]), .cpThirdKindStripe(det[15]),
      .cpColourStripe(det[14]), .cpPseudoSync(det[13]), .vsyncLevel(det[12]), .rateConvFifoUnderflow(det[11]),
      .rateConvFifoOverflow(det[10]), .fieldOdd(det[9]), .detectedStandardCode(det[8:5]),
      .gainCtrlLocked(det[4]), .subcarrierLocked(det[3]), .verticalLocked(det[2]), .rateConvLocked(det[1]),
      .horizontalLocked(det[0]), .vsyncPulse(vsPulse), .currentLine(curLine), .expectedVsyncLine(expLine),
      .hsyncPulse(hsPulse), .hsyncPhaseError(hsErr), .firstAncIdentWordLow(firstLow),
      .secondAncIdentWordLow(secondLow), .tenBitOutputSel(tenBit), .audioGroupSel(grpSel),
      .audioSampleRate(rateSel), .fifoInsertEnable(fifoEn), .specialPlayN(spN), .videoPresentFlag(video_present_flag));

   // 100 MHz clock
   initial
   begin
      forever #5 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // Write with address and data offered together, bready held until the response
   task automatic axWrite(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge clock);
      awAddr <= a;
      wData <= {24'h000000, d};
      wStrb <= s;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clock);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
         if (bValid)
         begin
            r = bResp;
            bReady <= 1'b0;
            return;
         end
      end
      n_mismatch++;
      conclude();
   endtask : axWrite

   task automatic axRead(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clock);
         if (arReady) arValid <= 1'b0;
         if (rValid)
         begin
            d = rData;
            r = rResp;
            rReady <= 1'b0;
            return;
         end
      end
      n_mismatch++;
      conclude();
   endtask : axRead

   task automatic rdChk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axRead(a, d, r);
      chk(d & m, e);
   endtask : rdChk

   // One-cycle sync pulses: vsync carries the line, hsync the phase error
   task automatic pulse(input logic v, input logic [9:0] x, input int n);
      repeat (n)
      begin
         curLine <= x;
         hsErr <= x[7:0];
         vsPulse <= v;
         hsPulse <= !v;
         @(posedge clock);
         vsPulse <= 1'b0;
         hsPulse <= 1'b0;
         @(posedge clock);
      end
   endtask : pulse
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      chk({firstLow, secondLow, tenBit, grpSel, rateSel, fifoEn, spN, video_present_flag}, 32'h0);
      rdChk(16'h1034, 32'hff, 32'h01);
      foreach (rows[k])
      begin
         axWrite(rows[k].a, rows[k].wd, 4'h1, resp);
         chk(resp, rows[k].resp);
         chk({firstLow, secondLow, tenBit, grpSel, rateSel, fifoEn}, rows[k].outs);
         axRead(rows[k].a, rd, resp);
         chk(resp, rows[k].resp);
         chk(rd, rows[k].rd);
      end
      // A write with its byte lane off leaves the register alone
      axWrite(16'h102c, 8'h00, 4'h0, resp);
      chk(resp, 32'h0);
      rdChk(16'h102c, 32'hff, 32'h3d);
      // Status snapshot against the live detector levels
      foreach (pats[k])
      begin
         det <= pats[k];
         tick(2);
         cpE = {det[16:15], det[14] | det[15], det[13], 2'b00,
                det[13] ? (det[15] ? 2'h3 : (det[14] ? 2'h2 : 2'h1)) : 2'h0};
         rdChk(16'h1030, 32'hff, {24'h0, cpE});
         rdChk(16'h1034, 32'hff, {24'h0, det[12:5]});
         rdChk(16'h1038, 32'h9f, {27'h0, det[4:0]});
      end
      foreach (codes[k])
      begin
         det[8:5] <= codes[k];
         tick(2);
         rdChk(16'h1034, 32'h0f, {28'h0, codes[k]});
      end
      // Vsync at the edges of the window around line 100
      foreach (spRows[k])
      begin
         pulse(1'b1, spRows[k][10:1], 1);
         tick(1);
         chk(spN, spRows[k][0]);
      end
      rdChk(16'h1038, 32'h40, 32'h40);
      // Presence from hsync history, then with vertical qualification
      foreach (prRows[k])
      begin
         if (prRows[k][6])
            axWrite(16'h107c, 8'h01, 4'h1, resp);
         pulse(1'b1, 10'd100, int'(prRows[k][5:1]));
         pulse(1'b0, {2'b00, prRows[k][20:13]}, int'(prRows[k][12:7]));
         tick(2);
         chk(video_present_flag, prRows[k][0]);
      end
      rdChk(16'h1038, 32'h60, 32'h60);
      conclude();
   end
endmodule : vasr_status_bank_tb_top
